// >>> modulation_symbol_coder_bench.sv
// self-checking bench for the modulation symbol coder
`timescale 1ns/1ns
module modulation_symbol_coder_bench;
    logic       clk_in = 1'b0, rst_b_in = 1'b0, enable_in = 1'b0, rate_ok_in = 1'b1, go = 1'b0;
    logic [2:0] coding_in = 3'h0, data = 3'h0, sym_in, sym_out, phase_out;
    logic [1:0] mod_in = 2'h0, bits_in = 2'h3;
    logic       sym_valid_in, sym_valid_out, phase_valid_out, conflict_out, others_off_out, active_out;
    int         err_count = 0, samples_checked = 0, hist, prevd, x;
    int         q[$];
    int         cod[9] = '{0, 1, 2, 3, 4, 5, 6, 7, 0}, md[9] = '{0, 0, 2, 3, 2, 0, 1, 1, 1};
    int         kk[9] = '{3, 2, 3, 1, 3, 2, 2, 2, 2}, vdl[8] = '{0, 1, 3, 2, 7, 6, 4, 5};
    int         p_none[4] = '{1, 3, 5, 7}, p_std[4] = '{1, 3, 7, 5}, p_tfts[4] = '{5, 3, 7, 1};
    always #50 clk_in = ~clk_in;
    msc_source src (.clk_in(clk_in), .go_in(go), .data_in(data), .valid_out(sym_valid_in), .sym_out(sym_in));
    msc_symbol_coder dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .enable_in(enable_in), .coding_in(coding_in),
        .mod_in(mod_in), .bits_in(bits_in), .rate_ok_in(rate_ok_in), .sym_valid_in(sym_valid_in),
        .sym_in(sym_in), .sym_valid_out(sym_valid_out), .sym_out(sym_out), .phase_out(phase_out),
        .phase_valid_out(phase_valid_out), .conflict_out(conflict_out), .others_off_out(others_off_out),
        .active_out(active_out));
    task automatic chk(input string n, input logic [2:0] exp, input logic [2:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", n, exp, got);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // packs compare-symbol flag, coded symbol, phase-valid and phase
    function automatic int model(int c, int m, int k, int a);
        int b, ph, pv, eq;
        pv = (m == 1 || c == 4);
        ph = m != 1 ? vdl[a] : c == 6 ? p_std[a] : c == 7 ? p_tfts[a] : p_none[a];
        eq = (a[1] == a[0]);
        case (c)
            1: b = (a + hist) % (1 << k);
            2: b = ((a ^ (a >> 1)) + hist) % (1 << k);
            3: b = (a ^ prevd) ^ 1;
            5: b = {a[1] ^ (eq ? hist[1] : hist[0]), a[0] ^ (eq ? hist[0] : hist[1])};
            default: b = a;
        endcase
        hist = b;
        prevd = a;
        return (int'(m != 1 || c == 0) << 8) | (b << 4) | (pv << 3) | ph;
    endfunction
    always @(posedge clk_in) begin
        #2;
        if (sym_valid_out === 1'b1) begin
            if (q.size() == 0) chk("unexpected symbol", 3'h0, 3'h1);
            else begin
                x = q.pop_front();
                if (x[8]) chk("coded symbol", x[6:4], sym_out);
                chk("phase valid", {2'h0, x[3]}, {2'h0, phase_valid_out});
                if (x[3]) chk("phase", x[2:0], phase_out);
            end
        end
    end
    initial begin
        x = $urandom(8);
        repeat (4) @(posedge clk_in);
        #1 rst_b_in = 1'b1;
        for (int t = 0; t < 9; t++) begin
            enable_in = 1'b0;
            coding_in = cod[t][2:0];
            mod_in = md[t][1:0];
            bits_in = kk[t][1:0];
            repeat (2) @(posedge clk_in);
            #1 enable_in = 1'b1;
            hist = 0;
            prevd = 0;
            @(posedge clk_in) #1;
            chk("active", 3'h1, {2'h0, active_out});
            // back to back symbols, no gap
            repeat (12) begin
                go = 1'b1;
                data = 3'($urandom % (1 << kk[t]));
                q.push_back(model(cod[t], md[t], kk[t], int'(data)));
                @(posedge clk_in) #1;
            end
            go = 1'b0;
            repeat (4) @(posedge clk_in) #1;
        end
        coding_in = msc_pkg::CODE_GSM;
        repeat (2) @(posedge clk_in) #1;
        chk("conflict", 3'h1, {2'h0, conflict_out});
        go = 1'b1;
        repeat (3) @(posedge clk_in) #1;
        go = 1'b0;
        coding_in = msc_pkg::CODE_NONE;
        rate_ok_in = 1'b0;
        repeat (3) @(posedge clk_in) #1;
        chk("conflict rate", 3'h1, {2'h0, conflict_out});
        rate_ok_in = 1'b1;
        repeat (2) @(posedge clk_in) #1;
        chk("conflict gone", 3'h0, {2'h0, conflict_out});
        chk("others off", 3'h1, {2'h0, others_off_out});
        enable_in = 1'b0;
        repeat (2) @(posedge clk_in) #1;
        chk("others back", 3'h0, {2'h0, others_off_out});
        chk("pending", 3'h0, 3'(q.size()));
        tally_and_finish();
    end
    initial begin
        #(100 * 400);
        err_count++;
        tally_and_finish();
    end
endmodule // modulation_symbol_coder_bench
bind msc_symbol_coder msc_coder_properties chk_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .enable_in(enable_in),
    .coding_in(coding_in), .mod_in(mod_in), .bits_in(bits_in), .rate_ok_in(rate_ok_in),
    .sym_valid_in(sym_valid_in), .sym_in(sym_in), .sym_valid_out(sym_valid_out), .sym_out(sym_out),
    .phase_out(phase_out), .phase_valid_out(phase_valid_out), .conflict_out(conflict_out),
    .others_off_out(others_off_out), .active_out(active_out));

// >>> msc_coder_properties.sv
// port checker for the modulation symbol coder
`timescale 1ns/1ns
module msc_coder_properties (
    input wire logic       clk_in,
    input wire logic       rst_b_in,
    input wire logic       enable_in,
    input wire logic [2:0] coding_in,
    input wire logic [1:0] mod_in,
    input wire logic [1:0] bits_in,
    input wire logic       rate_ok_in,
    input wire logic       sym_valid_in,
    input wire logic [2:0] sym_in,
    input wire logic       sym_valid_out,
    input wire logic [2:0] sym_out,
    input wire logic [2:0] phase_out,
    input wire logic       phase_valid_out,
    input wire logic       conflict_out,
    input wire logic       others_off_out,
    input wire logic       active_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    wire tk = sym_valid_in && active_out;
    wire dq = tk && mod_in == msc_pkg::MOD_DQPSK;
    take_pulse_a: assert property (tk |=> sym_valid_out) else $error("symbol lost");
    idle_quiet_a: assert property (!tk |=> !sym_valid_out) else $error("stray symbol");
    none_pass_a: assert property (tk && coding_in == msc_pkg::CODE_NONE && bits_in == 2'h3
        |=> sym_out == $past(sym_in)) else $error("plain symbol altered");
    dq_pulse_a: assert property (dq |=> phase_valid_out) else $error("no phase step");
    dq_plain_a: assert property (dq && coding_in == msc_pkg::CODE_NONE && sym_in[1:0] == 2'h2
        |=> phase_out == msc_pkg::PH_M135) else $error("plain phase wrong");
    dq_std_a: assert property (dq && coding_in == msc_pkg::CODE_STD && sym_in[1:0] == 2'h2
        |=> phase_out == msc_pkg::PH_M45) else $error("standard phase wrong");
    dq_tfts_a: assert property (dq && coding_in == msc_pkg::CODE_TFTS && sym_in[1:0] == 2'h0
        |=> phase_out == msc_pkg::PH_M135) else $error("tfts phase wrong");
    bad_rate_a: assert property (enable_in && !rate_ok_in |=> conflict_out) else $error("no conflict");
    others_off_a: assert property (1'b1 |=> others_off_out == $past(enable_in)) else $error("others");
endmodule // msc_coder_properties

// >>> msc_phase_lut.sv
// phase-shift lookup for pi/4 dqpsk and vdl coding
`timescale 1ns/1ns
module msc_phase_lut (
    input  wire logic [2:0] code_in,
    input  wire logic [2:0] sym_in,
    output logic      [2:0] phase_out
);
    always_comb begin
        phase_out = msc_pkg::PH_ZERO;
        case (code_in)
            msc_pkg::CODE_STD: begin
                case (sym_in[1:0])
                    2'h0:    phase_out = msc_pkg::PH_P45;
                    2'h1:    phase_out = msc_pkg::PH_P135;
                    2'h2:    phase_out = msc_pkg::PH_M45;
                    default: phase_out = msc_pkg::PH_M135;
                endcase
            end
            msc_pkg::CODE_TFTS: begin
                case (sym_in[1:0])
                    2'h0:    phase_out = msc_pkg::PH_M135;
                    2'h1:    phase_out = msc_pkg::PH_P135;
                    2'h2:    phase_out = msc_pkg::PH_M45;
                    default: phase_out = msc_pkg::PH_P45;
                endcase
            end
            msc_pkg::CODE_VDL: begin
                case (sym_in)
                    3'h0:    phase_out = 3'h0;
                    3'h1:    phase_out = 3'h1;
                    3'h2:    phase_out = 3'h3;
                    3'h3:    phase_out = 3'h2;
                    3'h4:    phase_out = 3'h7;
                    3'h5:    phase_out = 3'h6;
                    3'h6:    phase_out = 3'h4;
                    default: phase_out = 3'h5;
                endcase
            end
            default: begin
                case (sym_in[1:0])
                    2'h0:    phase_out = msc_pkg::PH_P45;
                    2'h1:    phase_out = msc_pkg::PH_P135;
                    2'h2:    phase_out = msc_pkg::PH_M135;
                    default: phase_out = msc_pkg::PH_M45;
                endcase
            end
        endcase
    end
endmodule // msc_phase_lut

// >>> msc_pkg.sv
// package of constants and types for the modulation symbol coder
package msc_pkg;
    // coding selections
    localparam logic [2:0] CODE_NONE   = 3'h0;
    localparam logic [2:0] CODE_DIFF   = 3'h1;
    localparam logic [2:0] CODE_GDIFF  = 3'h2;
    localparam logic [2:0] CODE_GSM    = 3'h3;
    localparam logic [2:0] CODE_VDL    = 3'h4;
    localparam logic [2:0] CODE_PHDIFF = 3'h5;
    localparam logic [2:0] CODE_STD    = 3'h6;
    localparam logic [2:0] CODE_TFTS   = 3'h7;
    // modulation selections
    localparam logic [1:0] MOD_GENERIC = 2'h0;
    localparam logic [1:0] MOD_DQPSK   = 2'h1;
    localparam logic [1:0] MOD_EIGHT   = 2'h2;
    localparam logic [1:0] MOD_BINARY  = 2'h3;
    // phase in units of 45 degrees, modulo 8
    localparam logic [2:0] PH_P45   = 3'h1;
    localparam logic [2:0] PH_P135  = 3'h3;
    localparam logic [2:0] PH_M135  = 3'h5;
    localparam logic [2:0] PH_M45   = 3'h7;
    localparam logic [2:0] PH_ZERO  = 3'h0;
    localparam int         SYM_W    = 3;
    localparam int         MAX_K    = 3;
    localparam logic [2:0] RST_SYM  = 3'h0;
    // state machine, one-hot
    typedef enum logic [2:0] {
        ST_OFF      = 3'b001,
        ST_RUN      = 3'b010,
        ST_CONFLICT = 3'b100
    } msc_state_t;
endpackage

// >>> msc_source.sv
// symbol data source feeding the coder
`timescale 1ns/1ns
module msc_source (
    input  wire logic       clk_in,
    input  wire logic       go_in,
    input  wire logic [2:0] data_in,
    output logic            valid_out,
    output logic      [2:0] sym_out
);
    initial begin valid_out = 1'b0; sym_out = 3'h0; end
    // idle data inverts so a stale symbol cannot pass unseen
    always @(posedge clk_in) begin
        valid_out <= #1 go_in;
        sym_out   <= #1 go_in ? data_in : ~sym_out;
    end
endmodule // msc_source

// >>> msc_symbol_coder.sv
// modulation symbol coder top
`timescale 1ns/1ns
module msc_symbol_coder (
    input  wire logic       clk_in,
    input  wire logic       rst_b_in,
    input  wire logic       enable_in,
    input  wire logic [2:0] coding_in,
    input  wire logic [1:0] mod_in,
    input  wire logic [1:0] bits_in,
    input  wire logic       rate_ok_in,
    input  wire logic       sym_valid_in,
    input  wire logic [2:0] sym_in,
    output logic            sym_valid_out,
    output logic      [2:0] sym_out,
    output logic      [2:0] phase_out,
    output logic            phase_valid_out,
    output logic            conflict_out,
    output logic            others_off_out,
    output logic            active_out
);
    msc_pkg::msc_state_t state_ff, nxt_state;
    logic [2:0] prev_ff;
    logic       prev_bit_ff;
    logic [2:0] sym_ff;
    logic       valid_ff;
    logic [2:0] phase_ff;
    logic       phase_v_ff;
    logic       conflict_ff;
    logic       others_ff;

    // k-bit mask from bits per symbol; 0 treated as 3
    wire  [2:0] kmask      = (bits_in == 2'h1) ? 3'h1 : (bits_in == 2'h2) ? 3'h3 : 3'h7;
    wire  [2:0] in_sym     = sym_in & kmask;
    wire  [2:0] gray_sym   = (in_sym ^ (in_sym >> 1)) & kmask;
    wire  [2:0] diff_sum   = (in_sym + prev_ff) & kmask;
    wire  [2:0] gdiff_sum  = (gray_sym + prev_ff) & kmask;
    wire        gsm_bit    = ~(sym_in[0] ^ prev_bit_ff);
    wire        match      = ~(sym_in[1] ^ sym_in[0]);
    wire        pd_b1      = match ? (sym_in[1] ^ prev_ff[1]) : (sym_in[1] ^ prev_ff[0]);
    wire        pd_b0      = match ? (sym_in[0] ^ prev_ff[0]) : (sym_in[0] ^ prev_ff[1]);
    wire        is_dqpsk   = (mod_in == msc_pkg::MOD_DQPSK);

    // mode and width decodes
    wire        is_binary  = (mod_in == msc_pkg::MOD_BINARY);
    wire        is_eight   = (mod_in == msc_pkg::MOD_EIGHT);
    wire        k_one      = (bits_in == 2'h1);
    wire        k_two      = (bits_in == 2'h2);
    wire        k_three    = (bits_in == 2'h3);

    // legal combinations, a reduced view of the permitted coding table;
    // anything unlisted is refused so an odd mix is mapped at most in the one cycle before the state leaves run
    wire        ok_none    = (coding_in == msc_pkg::CODE_NONE);
    wire        ok_diff    = !is_dqpsk && ((coding_in == msc_pkg::CODE_DIFF) || (coding_in == msc_pkg::CODE_GDIFF));
    wire        ok_gsm     = is_binary && k_one && (coding_in == msc_pkg::CODE_GSM);
    wire        ok_vdl     = is_eight && k_three && (coding_in == msc_pkg::CODE_VDL);
    wire        ok_phdiff  = !is_dqpsk && k_two && (coding_in == msc_pkg::CODE_PHDIFF);
    wire        ok_psk     = is_dqpsk && ((coding_in == msc_pkg::CODE_STD) || (coding_in == msc_pkg::CODE_TFTS));
    wire        legal_code = ok_none || ok_diff || ok_gsm || ok_vdl || ok_phdiff || ok_psk;
    wire        conflict   = !(legal_code && rate_ok_in);

    logic [2:0] coded;
    always_comb begin
        case (coding_in)
            msc_pkg::CODE_NONE:   coded = in_sym;
            msc_pkg::CODE_DIFF:   coded = diff_sum;
            msc_pkg::CODE_GDIFF:  coded = gdiff_sum;
            msc_pkg::CODE_GSM:    coded = {2'h0, gsm_bit};
            msc_pkg::CODE_PHDIFF: coded = {1'h0, pd_b1, pd_b0};
            // vdl and the pi/4 codings carry the symbol itself, the phase lut does the work
            msc_pkg::CODE_VDL:    coded = in_sym;
            msc_pkg::CODE_STD:    coded = in_sym;
            msc_pkg::CODE_TFTS:   coded = in_sym;
            default:              coded = in_sym;
        endcase
    end

    wire        run_state  = (state_ff == msc_pkg::ST_RUN);
    wire        take       = run_state && sym_valid_in;
    // symbol history kept only for the recursive codings; the gsm input bit is kept for every coding
    wire        keeps_hist = (coding_in == msc_pkg::CODE_DIFF) || (coding_in == msc_pkg::CODE_GDIFF) ||
                             (coding_in == msc_pkg::CODE_PHDIFF);
    wire  [2:0] nxt_prev   = !take ? prev_ff : (keeps_hist ? coded : msc_pkg::RST_SYM);
    wire        nxt_pbit   = take ? sym_in[0] : prev_bit_ff;
    wire  [2:0] phase_sel;
    wire        phase_need = is_dqpsk || (coding_in == msc_pkg::CODE_VDL);

    msc_phase_lut u_lut (
        .code_in   (coding_in),
        .sym_in    (in_sym),
        .phase_out (phase_sel)
    );

    // run and conflict are left the same way; enable low always wins
    msc_pkg::msc_state_t on_state;
    assign on_state = conflict ? msc_pkg::ST_CONFLICT : msc_pkg::ST_RUN;

    always_comb begin
        case (state_ff)
            msc_pkg::ST_OFF: begin
                nxt_state = enable_in ? on_state : msc_pkg::ST_OFF;
            end
            msc_pkg::ST_RUN: begin
                nxt_state = enable_in ? on_state : msc_pkg::ST_OFF;
            end
            msc_pkg::ST_CONFLICT: begin
                nxt_state = enable_in ? on_state : msc_pkg::ST_OFF;
            end
            default: begin
                nxt_state = msc_pkg::ST_OFF;
            end
        endcase
    end

    // next values of the output registers
    wire  [2:0] nxt_sym      = take ? coded : sym_ff;
    wire        nxt_valid    = take;
    wire        nxt_phase_v  = take && phase_need;
    wire  [2:0] nxt_phase    = nxt_phase_v ? phase_sel : phase_ff;
    wire        nxt_conflict = enable_in && conflict;
    wire        nxt_others   = enable_in;

    // history registers; leaving run clears history so a new burst starts clean
    wire  [2:0] nxt_hist     = run_state ? nxt_prev : msc_pkg::RST_SYM;
    wire        nxt_hbit     = run_state ? nxt_pbit : 1'b0;

    // one register to a block; symbols flow only while running, conflicts mute them
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_ff <= msc_pkg::ST_OFF;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            prev_ff <= msc_pkg::RST_SYM;
        end else begin
            prev_ff <= nxt_hist;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            prev_bit_ff <= 1'b0;
        end else begin
            prev_bit_ff <= nxt_hbit;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sym_ff <= msc_pkg::RST_SYM;
        end else begin
            sym_ff <= nxt_sym;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            valid_ff <= 1'b0;
        end else begin
            valid_ff <= nxt_valid;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            phase_ff <= msc_pkg::PH_ZERO;
        end else begin
            phase_ff <= nxt_phase;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            phase_v_ff <= 1'b0;
        end else begin
            phase_v_ff <= nxt_phase_v;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            conflict_ff <= 1'b0;
        end else begin
            conflict_ff <= nxt_conflict;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            others_ff <= 1'b0;
        end else begin
            others_ff <= nxt_others;
        end
    end

    assign sym_valid_out   = valid_ff;
    assign sym_out         = sym_ff;
    assign phase_out       = phase_ff;
    assign phase_valid_out = phase_v_ff;
    assign conflict_out    = conflict_ff;
    assign others_off_out  = others_ff;
    assign active_out      = state_ff[1];
endmodule // msc_symbol_coder
